// file: rtl/asramc_ctrl.sv
// Controller that runs read and write cycles on a 2048 x 8 static memory
// Overview of operation
// - Hold each read address at least the read cycle time.
// - Allow at least write cycle time between write addresses.
// - Hold select low at least select-to-end-of-write time.
// - Address stable at least 10 ns before write falls.
// - Keep select and write overlap at least the pulse width.
// - Hold write address at least 0 ns after write ends.
// - Data valid setup time before write end, 5 ns hold after.
// - Hold write data 5 ns after write or select rises.
// - Write enable stays high whenever an address line changes.
// - Never drive opposite data while memory may still drive.
module asramc_ctrl #(
    parameter int ADDR_W = asramc_pkg::ADDR_W,
    parameter int DATA_W = asramc_pkg::DATA_W,
    parameter int GRADE = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_cs_n,
    output logic mem_oe_n,
    output logic mem_we_n,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in
);
    // Phase lengths in cycles for the chosen grade
    localparam logic [asramc_pkg::CNT_W-1:0] C_AS =
        asramc_pkg::min_cyc(asramc_pkg::T_AS_NS);
    localparam logic [asramc_pkg::CNT_W-1:0] C_WP =
        asramc_pkg::min_cyc(asramc_pkg::T_WP_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_EW =
        asramc_pkg::min_cyc(asramc_pkg::T_EW_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_DS =
        asramc_pkg::min_cyc(asramc_pkg::T_DS_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_DH =
        asramc_pkg::min_cyc(asramc_pkg::T_DH_NS);
    localparam logic [asramc_pkg::CNT_W-1:0] C_WC =
        asramc_pkg::min_cyc(asramc_pkg::T_WC_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_RC =
        asramc_pkg::min_cyc(asramc_pkg::T_RC_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_AA =
        asramc_pkg::min_cyc(asramc_pkg::T_AA_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_OE =
        asramc_pkg::min_cyc(asramc_pkg::T_OE_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_CHZ =
        asramc_pkg::min_cyc(asramc_pkg::T_CHZ_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_OHZ =
        asramc_pkg::min_cyc(asramc_pkg::T_OHZ_NS[GRADE]);
    localparam logic [asramc_pkg::CNT_W-1:0] C_WHZ =
        asramc_pkg::min_cyc(asramc_pkg::T_WHZ_NS[GRADE]);
    // Two synchroniser cycles plus one for data landing on the edge
    localparam logic [asramc_pkg::CNT_W-1:0] C_SYNC = 5'h03;
    // Wait for access: longer of address and enable access
    localparam logic [asramc_pkg::CNT_W-1:0] C_ACC_RAW =
        (C_AA > C_OE) ? C_AA : C_OE;
    localparam logic [asramc_pkg::CNT_W-1:0] C_ACC = C_ACC_RAW + C_SYNC;
    // Write pulse covers pulse width, select-to-end and data setup
    localparam logic [asramc_pkg::CNT_W-1:0] C_PW0 =
        (C_WP > C_EW) ? C_WP : C_EW;
    localparam logic [asramc_pkg::CNT_W-1:0] C_PULSE =
        (C_PW0 > C_DS) ? C_PW0 : C_DS;
    // Float time before the next cycle may drive the bus
    localparam logic [asramc_pkg::CNT_W-1:0] C_FLT0 =
        (C_CHZ > C_OHZ) ? C_CHZ : C_OHZ;
    localparam logic [asramc_pkg::CNT_W-1:0] C_FLOAT =
        (C_FLT0 > C_WHZ) ? C_FLT0 : C_WHZ;

    asramc_pkg::asramc_state_t state_q;
    logic [DATA_W-1:0] dq_sync;
    logic [asramc_pkg::CNT_W-1:0] elapsed_q;
    logic accept;

    asramc_tmr_if tif ();

    asramc_timer u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .t(tif)
    );

    // Data lines from the pins pass two flops before use
    asramc_sync #(
        .W(DATA_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(dq_in),
        .q(dq_sync)
    );

    assign accept = req_valid && req_ready;

    // Cycles since the address was last changed, for the cycle-time floor
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            elapsed_q <= '1;
        end else if (accept) begin
            elapsed_q <= '0;
        end else if (elapsed_q != '1) begin
            elapsed_q <= elapsed_q + 1'b1;
        end
    end

    // Sequencer and phase timer load
    always_comb begin
        tif.load = 1'b0;
        tif.count = '0;
        case (state_q)
            asramc_pkg::ASRAMC_IDLE: begin
                if (accept) begin
                    tif.load = 1'b1;
                    tif.count = req_write ? C_AS : C_ACC;
                end
            end
            asramc_pkg::ASRAMC_WR_SETUP: begin
                if (tif.done) begin
                    tif.load = 1'b1;
                    tif.count = C_PULSE;
                end
            end
            asramc_pkg::ASRAMC_WR_PULSE: begin
                if (tif.done) begin
                    tif.load = 1'b1;
                    tif.count = C_DH;
                end
            end
            asramc_pkg::ASRAMC_RD_WAIT: begin
                if (tif.done) begin
                    tif.load = 1'b1;
                    tif.count = C_FLOAT;
                end
            end
            asramc_pkg::ASRAMC_WR_HOLD: begin
                if (tif.done) begin
                    tif.load = 1'b1;
                    tif.count = C_FLOAT;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= asramc_pkg::ASRAMC_IDLE;
        end else begin
            case (state_q)
                asramc_pkg::ASRAMC_IDLE: begin
                    if (accept && req_write) begin
                        state_q <= asramc_pkg::ASRAMC_WR_SETUP;
                    end else if (accept) begin
                        state_q <= asramc_pkg::ASRAMC_RD_WAIT;
                    end
                end
                asramc_pkg::ASRAMC_WR_SETUP: begin
                    if (tif.done) begin
                        state_q <= asramc_pkg::ASRAMC_WR_PULSE;
                    end
                end
                asramc_pkg::ASRAMC_WR_PULSE: begin
                    if (tif.done) begin
                        state_q <= asramc_pkg::ASRAMC_WR_HOLD;
                    end
                end
                asramc_pkg::ASRAMC_WR_HOLD: begin
                    if (tif.done) begin
                        state_q <= asramc_pkg::ASRAMC_RECOVER;
                    end
                end
                asramc_pkg::ASRAMC_RD_WAIT: begin
                    if (tif.done) begin
                        state_q <= asramc_pkg::ASRAMC_RECOVER;
                    end
                end
                asramc_pkg::ASRAMC_RECOVER: begin
                    // Bus must float and the cycle time must pass
                    if (tif.done && elapsed_q >= C_RC &&
                        elapsed_q >= C_WC) begin
                        state_q <= asramc_pkg::ASRAMC_IDLE;
                    end
                end
                default: begin
                    state_q <= asramc_pkg::ASRAMC_IDLE;
                end
            endcase
        end
    end

    // Request port handshake and read return
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_q == asramc_pkg::ASRAMC_IDLE) && !accept;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_q == asramc_pkg::ASRAMC_RD_WAIT && tif.done) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= dq_sync;
            end
        end
    end

    // Address changes only when accepted, with write enable high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
        end else if (accept) begin
            mem_addr <= req_addr;
        end
    end

    // Memory control strobes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_cs_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_we_n <= 1'b1;
        end else begin
            mem_cs_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_we_n <= 1'b1;
            case (state_q)
                asramc_pkg::ASRAMC_IDLE: begin
                    if (accept && !req_write) begin
                        mem_cs_n <= 1'b0;
                        mem_oe_n <= 1'b0;
                    end else if (accept) begin
                        mem_cs_n <= 1'b0;
                    end
                end
                asramc_pkg::ASRAMC_RD_WAIT: begin
                    mem_cs_n <= tif.done;
                    mem_oe_n <= tif.done;
                end
                asramc_pkg::ASRAMC_WR_SETUP: begin
                    mem_cs_n <= 1'b0;
                    mem_we_n <= !tif.done;
                end
                asramc_pkg::ASRAMC_WR_PULSE: begin
                    // Write enable rises first; select follows in hold
                    mem_cs_n <= 1'b0;
                    mem_we_n <= tif.done;
                end
                asramc_pkg::ASRAMC_WR_HOLD: begin
                    mem_cs_n <= tif.done;
                end
                default: begin
                end
            endcase
        end
    end

    // Write data driven only with output enable high and after float
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            if (accept && req_write) begin
                dq_out <= req_wdata;
            end
            if (state_q == asramc_pkg::ASRAMC_IDLE) begin
                dq_oe <= accept && req_write;
            end else if (state_q == asramc_pkg::ASRAMC_WR_HOLD &&
                         tif.done) begin
                dq_oe <= 1'b0;
            end
        end
    end
endmodule // asramc_ctrl

// file: rtl/asramc_pkg.sv
// Package of timing constants and types for the asynchronous SRAM controller
package asramc_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Grade selection: 0 = fastest, 1 = middle, 2 = slowest
    localparam int GRADE_W = 2;
    // Read timing per grade, ns
    localparam int T_RC_NS [3] = '{100, 120, 150};
    localparam int T_AA_NS [3] = '{100, 120, 150};
    localparam int T_OE_NS [3] = '{35, 50, 55};
    localparam int T_OHZ_NS [3] = '{35, 35, 50};
    localparam int T_CHZ_NS [3] = '{40, 40, 55};
    localparam int T_PD_NS [3] = '{50, 60, 60};
    // Write timing per grade, ns
    localparam int T_WC_NS [3] = '{100, 120, 150};
    localparam int T_EW_NS [3] = '{80, 100, 120};
    localparam int T_WP_NS [3] = '{70, 85, 100};
    localparam int T_DS_NS [3] = '{40, 50, 60};
    localparam int T_WHZ_NS [3] = '{30, 35, 50};
    localparam int T_AS_NS = 10;
    localparam int T_DH_NS = 5;
    localparam int T_WR_NS = 0;
    localparam int CNT_W = 5;
    // Minimum times round up to whole cycles, never below one
    function automatic logic [CNT_W-1:0] min_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c < 1) begin
            c = 1;
        end
        return CNT_W'(c);
    endfunction
    typedef enum logic [2:0] {
        ASRAMC_IDLE,
        ASRAMC_RD_SETUP,
        ASRAMC_RD_WAIT,
        ASRAMC_RD_END,
        ASRAMC_WR_SETUP,
        ASRAMC_WR_PULSE,
        ASRAMC_WR_HOLD,
        ASRAMC_RECOVER
    } asramc_state_t;
endpackage

// file: rtl/asramc_tmr_if.sv
// Interface carrying the load and expiry of the shared phase timer
interface asramc_tmr_if;
    logic load;
    logic [asramc_pkg::CNT_W-1:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

// file: rtl/asramc_timer.sv
// Down counter that times each phase of a memory cycle
module asramc_timer (
    input wire logic clk,
    input wire logic rst_n,
    asramc_tmr_if.tmr t
);
    logic [asramc_pkg::CNT_W-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (t.load) begin
            cnt_q <= t.count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Done in the last cycle of a phase; load depends on done, so done
    // must not look back at load or the pair forms a loop
    assign t.done = cnt_q <= asramc_pkg::CNT_W'(1);
endmodule // asramc_timer

// file: rtl/asramc_sync.sv
// Two-flop synchroniser for the data lines read back from the memory
module asramc_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // asramc_sync

// file: verification/asramc_ctrl_assertions.sv
// Checker of the controller's pin timing towards the static memory
module asramc_ctrl_chk #(
    parameter int GRADE = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [10:0] mem_addr,
    input wire logic mem_cs_n,
    input wire logic mem_oe_n,
    input wire logic mem_we_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe
);
    function automatic int cyc(input int ns);
        return (ns + asramc_pkg::CLK_PERIOD_NS - 1) / 10;
    endfunction
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v == 8'hff) ? v : v + 8'h01;
    endfunction
    localparam int WC_C = cyc(asramc_pkg::T_WC_NS[GRADE]);
    localparam int EW_C = cyc(asramc_pkg::T_EW_NS[GRADE]);
    localparam int WP_C = cyc(asramc_pkg::T_WP_NS[GRADE]);
    localparam int DS_C = cyc(asramc_pkg::T_DS_NS[GRADE]);
    localparam int HZ_C = cyc(asramc_pkg::T_OHZ_NS[GRADE]);
    logic [10:0] addr_prev_q;
    logic [7:0] dq_prev_q, addr_age_q, oe_high_q, we_low_q, cs_low_q, dq_age_q;
    logic moved;
    assign moved = mem_addr != addr_prev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_prev_q <= 11'h000;
            dq_prev_q <= 8'h00;
            addr_age_q <= 8'hff;
            oe_high_q <= 8'hff;
        end else begin
            addr_prev_q <= mem_addr;
            dq_prev_q <= dq_out;
            addr_age_q <= moved ? 8'h01 : inc(addr_age_q);
            oe_high_q <= mem_oe_n ? inc(oe_high_q) : 8'h00;
        end
    end
    // Run lengths of write enable and select low and of stable driven data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_low_q <= 8'h00;
            cs_low_q <= 8'h00;
            dq_age_q <= 8'h00;
        end else begin
            we_low_q <= mem_we_n ? 8'h00 : inc(we_low_q);
            cs_low_q <= mem_cs_n ? 8'h00 : inc(cs_low_q);
            dq_age_q <= (dq_oe && dq_out == dq_prev_q) ?
                inc(dq_age_q) : 8'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence rd_open;
        $fell(mem_oe_n) && !mem_cs_n && mem_we_n;
    endsequence
    sequence rd_held;
        !mem_oe_n [*8] ##1 !mem_oe_n [*3];
    endsequence
    chk_addr_we_high: assert property (
        moved |-> mem_we_n && $past(mem_we_n))
        else $error("address moved with write enable low");
    chk_addr_spacing: assert property (
        moved |-> addr_age_q >= WC_C)
        else $error("address changed too soon");
    chk_addr_setup: assert property (
        $fell(mem_we_n) |-> $stable(mem_addr))
        else $error("no address setup before write");
    chk_write_pulse: assert property (
        $rose(mem_we_n) |-> we_low_q >= WP_C)
        else $error("write pulse too short");
    chk_select_end: assert property (
        $rose(mem_we_n) |-> !mem_cs_n && cs_low_q >= EW_C)
        else $error("select too short or ends with write");
    chk_data_setup_hold: assert property (
        $rose(mem_we_n) |-> dq_oe && $stable(dq_out) && dq_age_q >= DS_C)
        else $error("write data setup or hold broken");
    chk_cs_after_we: assert property (
        $rose(mem_cs_n) |-> mem_we_n && $past(mem_we_n) && !moved)
        else $error("select rose before write ended");
    chk_no_contend: assert property (
        $rose(dq_oe) |-> mem_oe_n && oe_high_q >= HZ_C)
        else $error("data driven before memory floats");
    chk_oe_in_write: assert property (
        !mem_we_n |-> mem_oe_n && dq_oe)
        else $error("output enable low during write");
    chk_read_answer: assert property (
        rd_open |-> rd_held ##[1:20] (rsp_valid && mem_oe_n))
        else $error("read access too short or unanswered");
    chk_ready_drop: assert property (
        req_valid && req_ready |-> ##[1:2] (!req_ready && !mem_cs_n))
        else $error("accepted request not started");
endmodule // asramc_ctrl_chk

bind asramc_ctrl asramc_ctrl_chk #(.GRADE(GRADE)) u_chk (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
    .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .dq_out(dq_out), .dq_oe(dq_oe)
);

// file: verification/asramc_mem_model.sv
// Behavioural model of the 2048 x 8 static memory on the far side
module asramc_mem_model #(
    parameter int ACC_NS = 100
) (
    input wire logic [10:0] addr,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq,
    output logic [7:0] q,
    output logic q_en,
    output logic standby
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [2048];
    logic rd_on, wr_on;
    assign standby = cs_n;
    assign rd_on = !cs_n && !oe_n && we_n;
    assign wr_on = !cs_n && !we_n;
    initial begin
        q = 8'h00;
        q_en = 1'b0;
    end
    // Drivers turn on 5 ns late and linger 30 ns after the read ends
    always @(rd_on) begin
        if (rd_on) begin
            q_en <= #5 1'b1;
        end else begin
            q_en <= #30 1'b0;
        end
    end
    // Old byte held, then garbage, then the stored byte
    always @(addr or rd_on) begin
        q <= #10 ~q;
        q <= #ACC_NS mem[addr];
    end
    always @(negedge wr_on) begin
        mem[addr] = dq;
    end
endmodule // asramc_mem_model

// file: verification/asramc_ctrl_test.sv
// Self-checking bench for the static memory controller
module asramc_ctrl_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_n, req_valid, req_write, req_ready, rsp_valid;
    logic mem_cs_n, mem_oe_n, mem_we_n, dq_oe, mem_q_en;
    logic [10:0] req_addr, mem_addr;
    logic [7:0] req_wdata, rsp_rdata, dq_out, dq_line, mem_q;
    logic [7:0] dq_last = 8'h00;
    logic [10:0] addrs [4] = '{11'h000, 11'h7ff, 11'h001, 11'h400};
    logic [7:0] datas [4] = '{8'ha5, 8'h5a, 8'hff, 8'h00};
    int num_errors = 0;
    int check_count = 0;
    int contend_cnt = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    asramc_ctrl dut (
        .clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
        .mem_we_n(mem_we_n), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_line)
    );
    asramc_mem_model #(.ACC_NS(100)) u_mem (
        .addr(mem_addr), .cs_n(mem_cs_n), .oe_n(mem_oe_n), .we_n(mem_we_n),
        .dq(dq_line), .q(mem_q), .q_en(mem_q_en), .standby()
    );
    // Undriven line shows the inverse of its last driven value
    assign dq_line = (dq_oe === 1'b1) ? dq_out :
        (mem_q_en === 1'b1) ? mem_q : ~dq_last;
    always @(dq_out or mem_q or dq_oe or mem_q_en) begin
        if (dq_oe === 1'b1) begin
            dq_last = dq_out;
        end else if (mem_q_en === 1'b1) begin
            dq_last = mem_q;
        end
    end
    always @(posedge clk) begin
        if (dq_oe === 1'b1 && mem_q_en === 1'b1) begin
            contend_cnt++;
        end
    end
    task automatic check_byte(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic do_req(input logic wr, input logic [10:0] a,
            input logic [7:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(negedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 100);
        if (req_ready !== 1'b1) num_errors++;
        @(posedge clk);
        req_valid <= 1'b0;
        @(posedge clk);
    endtask
    task automatic read_check(input logic [10:0] a, input logic [7:0] exp);
        int n;
        logic [7:0] got;
        n = 0;
        got = 8'hxx;
        do_req(1'b0, a, 8'h00);
        do begin
            @(negedge clk);
            n++;
        end while (rsp_valid !== 1'b1 && n < 40);
        if (rsp_valid === 1'b1) got = rsp_rdata;
        check_byte(exp, got);
        @(posedge clk);
    endtask
    task automatic test_fill();
        check_byte(8'h06, {5'h00, mem_cs_n, mem_we_n, dq_oe});
        for (int i = 0; i < 4; i++) do_req(1'b1, addrs[i], datas[i]);
        for (int i = 0; i < 4; i++) read_check(addrs[i], datas[i]);
        $display("test_fill done");
    endtask
    task automatic test_rewrite();
        do_req(1'b1, 11'h7ff, 8'h3c);
        read_check(11'h7ff, 8'h3c);
        do_req(1'b1, 11'h7ff, 8'hc3);
        read_check(11'h7ff, 8'hc3);
        read_check(11'h400, 8'h00);
        $display("test_rewrite done");
    endtask
    task automatic test_standby();
        int lows;
        lows = 0;
        repeat (200) begin
            @(negedge clk);
            if (mem_cs_n !== 1'b1) lows++;
        end
        @(posedge clk);
        check_byte(8'h00, 8'(lows));
        read_check(11'h000, 8'ha5);
        check_byte(8'h00, 8'(contend_cnt));
        $display("test_standby done");
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = 11'h000;
        req_wdata = 8'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_fill();
        test_rewrite();
        test_standby();
        finish_test();
    end
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule // asramc_ctrl_test
